// ===== rtl/idw_regs.vh
`ifndef IDW_REGS_VH
`define IDW_REGS_VH
// ==========================================================
// Register indices (byte address = index * 4)
`define IDW_IX_FEATURE 6'h01
`define IDW_IX_SECCNT 6'h02
`define IDW_IX_SECNUM 6'h03
`define IDW_IX_CYLLO 6'h04
`define IDW_IX_CYLHI 6'h05
`define IDW_IX_DRVHD 6'h06
`define IDW_IX_CMD 6'h07
`define IDW_IX_DMACTL 6'h08
`define IDW_IX_W88 6'h09
`define IDW_IX_ERASE 6'h0a
`define IDW_IX_APM 6'h0b
`define IDW_IX_SECUR 6'h0c
`define IDW_IX_PWRREQ 6'h0d
`define IDW_IX_KEYMGT 6'h0e
`define IDW_IX_ADVIDE 6'h0f
`define IDW_IX_ADVPC 6'h10
`define IDW_IX_PSTATE 6'h11
// ==========================================================
// Command opcodes
`define IDW_OP_IDLE_A 8'h97
`define IDW_OP_IDLE_B 8'he3
`define IDW_OP_UNLOCK 8'hf2
`define IDW_OP_ERASE 8'hf4
// ==========================================================
// Field positions and limits
`define IDW_SEC_EXPIRE 4
`define IDW_SEC_FAIL 16
`define IDW_SEC_WMASK 16'h012f
`define IDW_PWR_WMASK 16'hbfff
`define IDW_UDMA_MAX 3'h5
`define IDW_MW_MAX 3'h4
`define IDW_KIND_UDMA 2'h1
`define IDW_KIND_MW 2'h2
`define IDW_SEC_TRIES 3'h5
// ==========================================================
// Reset values
`define IDW_RST_DMACTL 10'h000
`define IDW_RST_APM 8'h00
`define IDW_RST_PWRREQ 16'h0000
// ==========================================================
// Timing: idle timer unit in ms, clock in kHz
`define IDW_UNIT_MS 5
`define IDW_CLK_KHZ 40000
// Product of the two above, sized to the 18-bit tick counter
`define IDW_UNIT_CYC 18'd200000
`endif

// ===== rtl/idw_top.v
// Behaviour
// - At most one DMA mode reported selected
// - Ultra and multiword selection mutually exclusive
// - Word 88 bits 12-8 flag selected UDMA
// - UDMA support bits are cumulative
// - Erase time byte: 0, 1-254 doubled, 255
// - Enhanced erase time uses same encoding
// - APM level held in low byte
// - Security bit 8 reports level
// - Expired count sets bit 4, aborts unlock and erase commands
// - Security bits 5,3,2,1,0 report state
// - Power word bit15 valid, bit14 zero
// - Bits 13/12 lack or disable level-1
// - Low twelve bits give max current
// - Key word bit 0, rest reserved
// - Max PIO field 2-0, 3-7 reserved
// - Max multiword field 5-3
// - Selected PIO field 8-6
// - Selected multiword field 11-9, 15-12 zero
// - I/O cycle field 2-0, 4-7 reserved
// - Memory cycle field 5-3, 15-6 zero
// - Idle: busy, idle mode, clear, interrupt
// - Nonzero count enables 5 ms power-down
//
// Decided for this implementation: the APB register port.
`include "idw_regs.vh"

module idw_top #(
  parameter [17:0] UNIT_CYC = `IDW_UNIT_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Device state
  output reg busy_status_flag,
  output reg intrq,
  output reg idle_mode,
  output reg power_down
);

  // ==========================================================
  // Bus decode
  localparam ST_READY = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_DONE = 2'h2;

  // Word index from the byte address; low bits must be zero
  // Anything outside the mapped range answers with an error
  // Decode uses the held address, valid through the access phase
  // Completion strobes fire only on the ready cycle
  wire [5:0] idx = paddr[7:2];
  wire acc = psel & penable;
  wire hit = (paddr[1:0] == 2'h0) && (idx >= `IDW_IX_FEATURE) &&
             (idx <= `IDW_IX_PSTATE);
  wire wr_go = acc & pready & pwrite & hit;
  wire rd_go = acc & pready & ~pwrite & hit;
  // Task file is locked while busy, as a host would see it
  wire tf_wr = wr_go & ~busy_status_flag;
  wire cmd_wr = tf_wr & (idx == `IDW_IX_CMD);
  wire [7:0] op = pwdata[7:0];

  // ==========================================================
  // Storage
  // Task file bytes are plain storage; only the count is used here
  // Configuration words stand in for the card's firmware settings
  // Everything clears on a power-on or hard reset
  reg [7:0] feature_param; // Task file bytes
  reg [7:0] sector_count_param;
  reg [7:0] sector_number_param;
  reg [7:0] cylinder_low_param;
  reg [7:0] cylinder_high_param;
  reg [7:0] drive_head_select;
  reg [9:0] dma_ctl; // [2:0] udma support, [6:4] mode, [9:8] kind
  reg [15:0] erase_time; // Normal low, enhanced high
  reg [7:0] apm_level;
  reg [15:0] security;
  reg [2:0] sec_tries; // Failed unlock attempts
  reg [15:0] power_req;
  reg media_content_protection;
  reg [11:0] adv_ide;
  reg [5:0] adv_pc;
  reg [1:0] state;
  reg err_flag; // Last command aborted
  reg abort_pend;
  reg apd_en;
  reg [7:0] apd_units; // Timeout in 5 ms units
  reg [7:0] units_left;
  reg [17:0] tick;
  reg [31:0] next_rdata;

  // ==========================================================
  // Derived identify words
  // Support is kept as a count, selection as kind plus mode
  // A count cannot describe a gap, so support stays cumulative
  // A single mode code cannot name two modes at once
  // Reserved bits of every word are tied to zero
  wire [2:0] usup = dma_ctl[2:0];
  wire [2:0] smode = dma_ctl[6:4];
  wire [1:0] skind = dma_ctl[9:8];
  wire [4:0] usup_bits;
  wire [4:0] usel_bits;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_udma
      // Support below a supported mode is implied
      assign usup_bits[gi] = (usup > gi);
      // One-hot from one code, so never two at once
      assign usel_bits[gi] = (skind == `IDW_KIND_UDMA) && (smode == gi);
    end
  endgenerate
  // Selected flags high, support flags low, reserved gaps zero
  wire [15:0] word88 = {3'h0, usel_bits, 3'h0, usup_bits};
  // Expire is forced into the reported word once the count runs out
  wire [15:0] sec_word = security | (16'h1 << `IDW_SEC_EXPIRE);
  wire expired = security[`IDW_SEC_EXPIRE];

  // Selection write accepted only if the mode exists
  // Support count above the top mode is clamped, not refused
  // Ultra selection must lie inside the supported range
  // With no kind chosen the mode code has to be zero
  wire [2:0] wsup = (pwdata[2:0] > `IDW_UDMA_MAX) ? `IDW_UDMA_MAX : pwdata[2:0];
  wire [2:0] wmode = pwdata[6:4];
  wire [1:0] wkind = pwdata[9:8];
  wire sel_ok = (wkind == `IDW_KIND_UDMA) ? (wmode < wsup) :
                (wkind == `IDW_KIND_MW) ? (wmode <= `IDW_MW_MAX) :
                (wmode == 3'h0);

  // ==========================================================
  // Read mux
  always @* begin
    // Default zero covers the unused upper bits of every word
    // Mux follows the address only; the answer stage latches it
    // Cost: one wide mux, but the read word is a clean register
    // Unmapped indices fall to the state word, then masked to zero
    next_rdata = 32'h0;
    if (idx == `IDW_IX_FEATURE) begin
      next_rdata[7:0] = feature_param;
    end else if (idx == `IDW_IX_SECCNT) begin
      next_rdata[7:0] = sector_count_param;
    end else if (idx == `IDW_IX_SECNUM) begin
      next_rdata[7:0] = sector_number_param;
    end else if (idx == `IDW_IX_CYLLO) begin
      next_rdata[7:0] = cylinder_low_param;
    end else if (idx == `IDW_IX_CYLHI) begin
      next_rdata[7:0] = cylinder_high_param;
    end else if (idx == `IDW_IX_DRVHD) begin
      next_rdata[7:0] = drive_head_select;
    end else if (idx == `IDW_IX_CMD) begin
      // Command slot reads back status: busy, ready, error
      next_rdata[7:0] = {busy_status_flag, ~busy_status_flag, 5'h0, err_flag};
    end else if (idx == `IDW_IX_DMACTL) begin
      next_rdata[9:0] = dma_ctl;
    end else if (idx == `IDW_IX_W88) begin
      next_rdata[15:0] = word88;
    end else if (idx == `IDW_IX_ERASE) begin
      next_rdata[15:0] = erase_time;
    end else if (idx == `IDW_IX_APM) begin
      next_rdata[7:0] = apm_level;
    end else if (idx == `IDW_IX_SECUR) begin
      next_rdata[15:0] = expired ? sec_word : security;
    end else if (idx == `IDW_IX_PWRREQ) begin
      next_rdata[15:0] = power_req;
    end else if (idx == `IDW_IX_KEYMGT) begin
      next_rdata[0] = media_content_protection;
    end else if (idx == `IDW_IX_ADVIDE) begin
      next_rdata[11:0] = adv_ide;
    end else if (idx == `IDW_IX_ADVPC) begin
      next_rdata[5:0] = adv_pc;
    end else begin
      next_rdata[7:0] = {sec_tries, expired, apd_en, power_down, idle_mode,
                         busy_status_flag};
    end
  end

  // ==========================================================
  // APB answer: one wait state, then ready for one cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      // First access edge raises ready, the next drops it again
      // A fixed wait state keeps read data a registered output
      // Error and data are judged on the same edge as ready
      // A back-to-back setup restarts the pattern cleanly
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc & ~pready) begin
        prdata <= hit ? next_rdata : 32'h0;
      end
    end
  end

  // ==========================================================
  // Task file and identify configuration writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      feature_param <= 8'h00;
      sector_count_param <= 8'h00;
      sector_number_param <= 8'h00;
      cylinder_low_param <= 8'h00;
      cylinder_high_param <= 8'h00;
      drive_head_select <= 8'h00;
      dma_ctl <= `IDW_RST_DMACTL;
      erase_time <= 16'h0000;
      apm_level <= `IDW_RST_APM;
      power_req <= `IDW_RST_PWRREQ;
      media_content_protection <= 1'b0;
      adv_ide <= 12'h000;
      adv_pc <= 6'h00;
    end else if (tf_wr) begin
      // Writes land on the ready edge only, never twice per transfer
      // Read-only words simply have no branch here
      // Busy blocks every write, as the host would see it
      if (idx == `IDW_IX_FEATURE) begin
        feature_param <= pwdata[7:0];
      end else if (idx == `IDW_IX_SECCNT) begin
        sector_count_param <= pwdata[7:0];
      end else if (idx == `IDW_IX_SECNUM) begin
        sector_number_param <= pwdata[7:0];
      end else if (idx == `IDW_IX_CYLLO) begin
        cylinder_low_param <= pwdata[7:0];
      end else if (idx == `IDW_IX_CYLHI) begin
        cylinder_high_param <= pwdata[7:0];
      end else if (idx == `IDW_IX_DRVHD) begin
        drive_head_select <= pwdata[7:0];
      end else if (idx == `IDW_IX_DMACTL) begin
        // Whole word or nothing: a bad pair could flag an unsupported mode
        if (sel_ok) begin
          dma_ctl <= {wkind, 1'b0, wmode, 1'b0, wsup};
        end
      end else if (idx == `IDW_IX_ERASE) begin
        erase_time <= pwdata[15:0];
      end else if (idx == `IDW_IX_APM) begin
        apm_level <= pwdata[7:0];
      end else if (idx == `IDW_IX_PWRREQ) begin
        power_req <= pwdata[15:0] & `IDW_PWR_WMASK;
      end else if (idx == `IDW_IX_KEYMGT) begin
        media_content_protection <= pwdata[0];
      end else if (idx == `IDW_IX_ADVIDE) begin
        // Reserved codes 3-7 leave a field unchanged
        if (pwdata[2:0] <= 3'h2) adv_ide[2:0] <= pwdata[2:0];
        if (pwdata[5:3] <= 3'h2) adv_ide[5:3] <= pwdata[5:3];
        if (pwdata[8:6] <= 3'h2) adv_ide[8:6] <= pwdata[8:6];
        if (pwdata[11:9] <= 3'h2) adv_ide[11:9] <= pwdata[11:9];
      end else if (idx == `IDW_IX_ADVPC) begin
        if (pwdata[2:0] <= 3'h3) adv_pc[2:0] <= pwdata[2:0];
        if (pwdata[5:3] <= 3'h3) adv_pc[5:3] <= pwdata[5:3];
      end
    end
  end

  // ==========================================================
  // Security status and attempt counter
  // Expire is sticky; only a reset of the card clears it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      security <= 16'h0000;
      sec_tries <= 3'h0;
    end else begin
      if (tf_wr && idx == `IDW_IX_SECUR) begin
        security <= (pwdata[15:0] & `IDW_SEC_WMASK) |
                    (security & ~`IDW_SEC_WMASK);
        if (pwdata[`IDW_SEC_FAIL] && sec_tries != `IDW_SEC_TRIES) begin
          sec_tries <= sec_tries + 3'h1;
        end
      end
      // Placed after the write so expiry wins over a same-cycle write
      // The count saturates, so expiry cannot be counted past
      // Only the asynchronous reset path ever clears this bit
      // Host writes never reach the expire bit through the mask
      if (sec_tries == `IDW_SEC_TRIES) begin
        security[`IDW_SEC_EXPIRE] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Command sequencer: busy, execute, complete with interrupt
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_READY;
      busy_status_flag <= 1'b0;
      intrq <= 1'b0;
      err_flag <= 1'b0;
      abort_pend <= 1'b0;
      idle_mode <= 1'b0;
      apd_en <= 1'b0;
      apd_units <= 8'h00;
    end else begin
      // Three steps: take, execute, complete
      // Unknown opcodes are not executed but still wake the card
      // Aborts reuse the same path so the host sees one protocol
      // Busy always covers exactly the execute and done cycles
      case (state)
        ST_READY: begin
          if (cmd_wr && (op == `IDW_OP_IDLE_A || op == `IDW_OP_IDLE_B)) begin
            busy_status_flag <= 1'b1;
            abort_pend <= 1'b0;
            state <= ST_EXEC;
          end else if (cmd_wr && expired &&
                       (op == `IDW_OP_UNLOCK || op == `IDW_OP_ERASE)) begin
            busy_status_flag <= 1'b1;
            abort_pend <= 1'b1;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // Count is read here, after the host has written it
          // An abort leaves idle mode and the timer setup untouched
          // Error bit reports the outcome of this command only
          if (!abort_pend) begin
            idle_mode <= 1'b1;
            apd_en <= (sector_count_param != 8'h00);
            apd_units <= sector_count_param;
          end
          err_flag <= abort_pend;
          state <= ST_DONE;
        end
        ST_DONE: begin
          busy_status_flag <= 1'b0;
          state <= ST_READY;
        end
        default: begin
          state <= ST_READY;
        end
      endcase
      // Completion raise beats a status read in the same cycle
      if (state == ST_DONE) begin
        intrq <= 1'b1;
      end else if (rd_go && idx == `IDW_IX_CMD) begin
        intrq <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Automatic power-down timer
  // Long unit count kept as a parameter so benches can shrink it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick <= 18'h0;
      units_left <= 8'h00;
      power_down <= 1'b0;
    end else if (cmd_wr || state == ST_EXEC) begin
      // Any command wakes the card and restarts the wait
      tick <= 18'h0;
      units_left <= (state == ST_EXEC && !abort_pend) ?
                    sector_count_param : apd_units;
      power_down <= 1'b0;
    end else if (apd_en && !power_down && !busy_status_flag) begin
      // Tick counts one unit, units count down the host's setting
      // Holding still while busy keeps the wait from the completion
      // Stopped once powered down, so no wrap or repeated expiry
      // A zero count never gets here, as the enable is then off
      if (tick == UNIT_CYC - 18'h1) begin
        tick <= 18'h0;
        if (units_left <= 8'h01) begin
          power_down <= 1'b1;
        end else begin
          units_left <= units_left - 8'h01;
        end
      end else begin
        tick <= tick + 18'h1;
      end
    end
  end

endmodule // idw_top

// ===== tb/identify_words_idle_cmd_tb.sv
// ==========
// Self-checking bench for the identify words and idle command
module identify_words_idle_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short timer unit keeps power-down waits brief
  localparam [17:0] UNIT = 18'd10;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic busy_status_flag, intrq, idle_mode, power_down;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  // Write index, write data, read index, expected read
  logic [43:0] rows [12] = '{
    {6'h0a, 16'hff01, 6'h0a, 16'hff01}, {6'h0b, 16'h0080, 6'h0b, 16'h0080},
    {6'h0c, 16'hffff, 6'h0c, 16'h012f}, {6'h0d, 16'hffff, 6'h0d, 16'hbfff},
    {6'h0e, 16'hffff, 6'h0e, 16'h0001}, {6'h0f, 16'h0291, 6'h0f, 16'h0291},
    {6'h0f, 16'hffff, 6'h0f, 16'h0291}, {6'h10, 16'h001a, 6'h10, 16'h001a},
    {6'h08, 16'h0135, 6'h09, 16'h081f}, {6'h08, 16'h0145, 6'h09, 16'h101f},
    {6'h08, 16'h0225, 6'h09, 16'h001f}, {6'h08, 16'h0003, 6'h09, 16'h0007}};
  // Idle opcode, count, power-down expected
  logic [16:0] idl [2] = '{{8'h97, 8'h00, 1'b0}, {8'he3, 8'h02, 1'b1}};
  logic [7:0] abt [2] = '{8'hf2, 8'hf4};
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  idw_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  idw_top #(.UNIT_CYC(UNIT)) dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy_status_flag(busy_status_flag), .intrq(intrq),
    .idle_mode(idle_mode), .power_down(power_down));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Power-on or hard reset, six cycles
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  initial begin
    do_reset();
    chk("state flags", 32'h0, {28'h0, busy_status_flag, intrq, idle_mode, power_down});
    host.xfer(1'b0, 6'h08, 32'h0, q, e);
    chk("dma ctl reset", 32'h0, q);
    // Table: write one word, read back the reported word
    foreach (rows[i]) begin
      host.xfer(1'b1, rows[i][43:38], {16'h0, rows[i][37:22]}, q, e);
      host.xfer(1'b0, rows[i][21:16], 32'h0, q, e);
      chk("table read", {16'h0, rows[i][15:0]}, q);
    end
    // Unmapped index is refused
    host.xfer(1'b0, 6'h20, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    // Both idle opcodes, timer off and on
    foreach (idl[i]) begin
      host.cmd(idl[i][16:9], idl[i][8:1]);
      repeat (2) @(posedge clk);
      chk("idle done", 32'h3, {29'h0, busy_status_flag, intrq, idle_mode});
      host.xfer(1'b0, 6'h07, 32'h0, q, e);
      chk("idle status", 32'h40, q);
      @(posedge clk);
      chk("intrq cleared", 32'h0, {31'h0, intrq});
      repeat (10) @(posedge clk);
      chk("early power down", 32'h0, {31'h0, power_down});
      repeat (20) @(posedge clk);
      chk("power down", {31'h0, idl[i][0]}, {31'h0, power_down});
    end
    // Any command wakes the card
    host.cmd(8'h00, 8'h02);
    chk("wake", 32'h0, {31'h0, power_down});
    // Five failed attempts expire the count, then abort
    repeat (5) host.xfer(1'b1, 6'h0c, 32'h0001_0000, q, e);
    host.xfer(1'b0, 6'h0c, 32'h0, q, e);
    chk("expired", 32'h1, {31'h0, q[4]});
    foreach (abt[i]) begin
      host.cmd(abt[i], 8'h00);
      repeat (2) @(posedge clk);
      host.xfer(1'b0, 6'h07, 32'h0, q, e);
      chk("abort status", 32'h41, q);
    end
    // Hard reset in mid-run clears the expiry
    do_reset();
    host.xfer(1'b0, 6'h0c, 32'h0, q, e);
    chk("expire cleared", 32'h0, {31'h0, q[4]});
    end_of_test();
  end
  // Hang guard, well beyond the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      end_of_test();
    end
  end
endmodule // identify_words_idle_cmd_tb
bind idw_top idw_top_properties #(.UNIT_CYC(UNIT_CYC)) props (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy_status_flag(busy_status_flag),
  .intrq(intrq), .idle_mode(idle_mode), .power_down(power_down));

// ===== tb/idw_host.sv
// ==========
// Host model: APB master on the task file
module idw_host (
  // Clock
  input wire logic clk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Setup, access until pready, then one idle cycle so calls never collide
  task automatic xfer(input logic w, input logic [5:0] ix, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge clk);
  endtask
  // Count must be in place before the opcode lands
  task automatic cmd(input logic [7:0] op, input logic [7:0] cnt);
    logic [31:0] q;
    logic e;
    xfer(1'b1, 6'h02, {24'h0, cnt}, q, e);
    xfer(1'b1, 6'h07, {24'h0, op}, q, e);
  endtask
endmodule // idw_host

// ===== tb/idw_top_properties.sv
// ==========
// Port checks for the identify word and idle block
module idw_top_properties #(
  parameter [17:0] UNIT_CYC = 18'd10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Device state
  input wire logic busy_status_flag,
  input wire logic intrq,
  input wire logic idle_mode,
  input wire logic power_down
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Completed transfer and its word index
  wire done = psel && penable && pready;
  wire rd = done && !pwrite;
  wire [5:0] ix = paddr[7:2];
  // Idle opcode taken while not busy
  wire idle_wr = done && pwrite && ix == 6'h07 && !busy_status_flag
    && (pwdata[7:0] == 8'h97 || pwdata[7:0] == 8'he3);
  // Busy two cycles, then interrupt as busy drops
  sequence busy_run;
    busy_status_flag [*2] ##1 (!busy_status_flag && intrq);
  endsequence
  a_idle_busy: assert property (idle_wr |=> busy_run)
    else $error("idle busy sequence wrong");
  a_idle_enter: assert property (idle_wr |-> ##2 idle_mode)
    else $error("idle mode not entered");
  a_idle_stay: assert property (idle_mode |=> idle_mode)
    else $error("idle mode dropped");
  a_apb_wait: assert property ($rose(penable) && psel |=> pready ##1 !pready)
    else $error("wait state wrong");
  a_bad_addr: assert property (pready |->
    pslverr == (paddr[1:0] != 2'h0 || ix == 6'h00 || ix > 6'h11))
    else $error("error response wrong");
  a_err_zero: assert property (rd && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_udma_sel: assert property (rd && ix == 6'h09 |-> $onehot0(prdata[12:8]))
    else $error("more than one mode selected");
  a_udma_rsv: assert property (rd && ix == 6'h09 |-> prdata[31:13] == '0 && prdata[7:5] == '0)
    else $error("reserved bits set");
  a_udma_cum: assert property (rd && ix == 6'h09 |-> (prdata[4:0] & (prdata[4:0] + 5'h01)) == '0)
    else $error("support bits not cumulative");
  a_pwr_rsv: assert property (rd && ix == 6'h0d |-> !prdata[14])
    else $error("power word bit 14 set");
  a_adv_rsv: assert property (rd && ix == 6'h0f |-> prdata[31:12] == '0 && prdata[2:0] < 3
    && prdata[5:3] < 3 && prdata[8:6] < 3 && prdata[11:9] < 3)
    else $error("reserved timing code stored");
  a_pd_wake: assert property (power_down && done && pwrite && ix == 6'h07 |=> ##[0:1] !power_down)
    else $error("command did not wake");
endmodule // idw_top_properties
